// *** bench/isolation_valve_actuation_logic_tb_top.sv ***
// Self-checking bench for one side of the valve actuation logic
`timescale 1ns/1ns
module isolation_valve_actuation_logic_tb_top;
  import valve_actuation_pkg::*;
  logic clk_sys, rst;
  logic [1:0] grp;
  logic [7:0] trip, cls, opn, byp, opr, pwr, fault;
  logic [7:0] status, ten, lamp, alarm;
  sol_t [7:0] sol, rb;
  reg_req_t req;
  logic [31:0] rdata, d;
  int failures, compares, v, p;
  ////////////////////////////////////////////////////////////////////////////
  // Short tick and hold so the run stays brief
  valve_actuation_logic #(.TICK_CYCLES(4), .CLOSE_HOLD_TICKS(20)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .group_close_in(grp),
    .protection_trip_in(trip), .close_pb_in(cls), .open_pb_in(opn),
    .bypass_pb_in(byp), .operate_pb_in(opr), .sol_power_in(pwr),
    .sol_readback_in(rb), .side_sol(sol), .status_out(status),
    .test_enable_out(ten), .bypass_lamp(lamp), .discrepancy_alarm(alarm),
    .reg_req(req), .reg_rdata(rdata));
  sol_model model_u (.side_sol(sol), .fault(fault), .readback(rb));
  ////////////////////////////////////////////////////////////////////////////
  // Expected solenoid pattern per state
  function automatic sol_t pat(input int s);
    return s == 0 ? 3'h0 : (s == 1 ? 3'h1 : 3'h6);
  endfunction : pat
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle
  // Wait bounded for a valve pattern, then compare
  task automatic wait_sol(input int i, input int s);
    for (int n = 0; n < 150 && sol[i] !== pat(s); n++) @(posedge clk_sys);
    #1 check(sol[i], pat(s));
  endtask : wait_sol
  // Momentary pushbutton, long enough for the debounce
  task automatic press(input int k, input int i);
    @(posedge clk_sys);
    case (k)
      0: grp[i] <= 1'b1;
      1: cls[i] <= 1'b1;
      2: opn[i] <= 1'b1;
      3: byp[i] <= 1'b1;
      default: opr[i] <= 1'b1;
    endcase
    idle(20);
    grp <= '0;
    {cls, opn, byp, opr} <= '0;
  endtask : press
  // One register access, read data taken the cycle after
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] x);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: x, wr: w, rd: !w};
    @(posedge clk_sys);
    req <= '0;
    #1 d = rdata;
  endtask : bus
  task automatic end_test(input string n);
    $display("test %s finished", n);
  endtask : end_test
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    idle(20000);
    failures++;
    final_report();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    {grp, cls, opn, byp, opr, fault} = '0;
    {trip, pwr} = '1;
    req = '0;
    failures = 0;
    compares = 0;
    v = $urandom(79844);
    v = $urandom % 4;
    idle(3);
    rst <= 1'b0;
    idle(40);
    for (int i = 0; i < 8; i++) check(sol[i], pat(2));
    check(status, 8'hff);
    check(ten, 8'h00);
    end_test("reset");
    press(0, 0);
    for (int i = 0; i < 4; i++) wait_sol(i, 0);
    check(sol[4], pat(2));
    idle(20);
    press(2, 1);
    idle(10);
    check(sol[1], pat(0));
    wait_sol(1, 1);
    press(2, v);
    wait_sol(v, 2);
    check(sol[(v + 1) % 4], pat(1));
    end_test("group close");
    @(posedge clk_sys);
    trip[4] <= 1'b0;
    idle(30);
    check(sol[4], pat(2));
    trip[5] <= 1'b0;
    for (int i = 4; i < 8; i++) wait_sol(i, 0);
    check(sol[v], pat(2));
    wait_sol(4, 1);
    press(2, 4);
    idle(30);
    check(sol[4], pat(1));
    trip <= '1;
    idle(30);
    press(1, v);
    wait_sol(v, 0);
    check(sol[(v + 1) % 4], pat(1));
    end_test("trip and single");
    press(3, 6);
    check({lamp[6], status[6], ten[6]}, 3'b101);
    press(0, 1);
    wait_sol(5, 0);
    check(sol[6], pat(1));
    press(4, 6);
    idle(10);
    check({lamp[6], ten[6], status[6]}, 3'b001);
    bus(1'b0, REG_STATE, 32'h0);
    check(d[13:12], 2'h1);
    bus(1'b0, 8'h3c, 32'h0);
    check(d, 32'h0);
    end_test("bypass and registers");
    p = $urandom % 8;
    @(posedge clk_sys);
    pwr[p] <= 1'b0;
    idle(30);
    check(status, 8'(~(8'h01 << p)));
    pwr <= '1;
    idle(100);
    fault[7] <= 1'b1;
    for (int n = 0; n < 400 && alarm[7] !== 1'b1; n++) @(posedge clk_sys);
    check(alarm, 8'h80);
    press(0, 1);
    wait_sol(4, 0);
    check(sol[7], pat(1));
    @(posedge clk_sys);
    fault <= '0;
    idle(30);
    bus(1'b1, REG_ALARM, 32'h80);
    bus(1'b0, REG_ALARM, 32'h0);
    check(d[9:7], 3'b100);
    end_test("read-back alarm");
    // Manually started test, then cut short by a single close
    p = $urandom % 8;
    bus(1'b1, REG_CTRL, 32'h1 | (p << CTRL_SEL_LSB));
    idle(2);
    check(status, 8'h00);
    check(ten, 8'h01 << p);
    bus(1'b0, REG_CTRL, 32'h0);
    check(d[1], 1'b1);
    press(1, 3);
    bus(1'b0, REG_ALARM, 32'h0);
    check(d[8], 1'b1);
    check(ten, 8'h00);
    end_test("manual test");
    final_report();
  end
endmodule : isolation_valve_actuation_logic_tb_top

// *** bench/sol_model.sv ***
// Solenoid driver read-back model with fault injection
`timescale 1ns/1ns
module sol_model (
  // Drives and injected faults
  input wire valve_actuation_pkg::sol_t [7:0] side_sol,
  input wire logic [7:0] fault,
  // Measured solenoid state
  output valve_actuation_pkg::sol_t [7:0] readback
);
  import valve_actuation_pkg::*;
  // Mirror the drives, invert a faulty valve
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      readback[i] = fault[i] ? ~side_sol[i] : side_sol[i];
    end
  end
endmodule : sol_model

// *** src/valve_actuation_logic.sv ***
// One side of eight isolation valves: commands, states, bypass and tests
`timescale 1ns/1ns
module valve_actuation_logic #(
  parameter int TICK_CYCLES = valve_actuation_pkg::TICK_CYCLES_DEF,
  parameter int CLOSE_HOLD_TICKS = valve_actuation_pkg::CLOSE_HOLD_MS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Field contacts, raw
  input wire logic [valve_actuation_pkg::N_GROUP-1:0] group_close_in,
  input wire logic [valve_actuation_pkg::N_VALVES-1:0] protection_trip_in,
  input wire logic [valve_actuation_pkg::N_VALVES-1:0] close_pb_in,
  input wire logic [valve_actuation_pkg::N_VALVES-1:0] open_pb_in,
  input wire logic [valve_actuation_pkg::N_VALVES-1:0] bypass_pb_in,
  input wire logic [valve_actuation_pkg::N_VALVES-1:0] operate_pb_in,
  input wire logic [valve_actuation_pkg::N_VALVES-1:0] sol_power_in,
  input wire valve_actuation_pkg::sol_t [valve_actuation_pkg::N_VALVES-1:0]
    sol_readback_in,
  // Solenoid and panel outputs
  output valve_actuation_pkg::sol_t [valve_actuation_pkg::N_VALVES-1:0]
    side_sol,
  output logic [valve_actuation_pkg::N_VALVES-1:0] status_out,
  output logic [valve_actuation_pkg::N_VALVES-1:0] test_enable_out,
  output logic [valve_actuation_pkg::N_VALVES-1:0] bypass_lamp,
  output logic [valve_actuation_pkg::N_VALVES-1:0] discrepancy_alarm,
  // Register port
  input wire valve_actuation_pkg::reg_req_t reg_req,
  output logic [valve_actuation_pkg::DATA_W-1:0] reg_rdata
);
  import valve_actuation_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Solenoid pattern required by a state
  function automatic sol_t pattern(input valve_state_t s);
    unique case (s)
      CLOSE_STATE: return SOL_CLOSE;
      KEEP_CLOSED_STATE: return SOL_KEEP;
      OPEN_STATE: return SOL_OPEN;
      default: return SOL_CLOSE;
    endcase
  endfunction : pattern

  // State implied by a solenoid read-back
  function automatic valve_state_t found_state(input sol_t r);
    if (r == SOL_OPEN) begin
      return OPEN_STATE;
    end
    if (r == SOL_KEEP) begin
      return KEEP_CLOSED_STATE;
    end
    return CLOSE_STATE;
  endfunction : found_state

  // Two-out-of-four vote
  function automatic logic vote_2oo4(input logic [GROUP_SIZE-1:0] c);
    logic [2:0] n;
    n = '0;
    for (int k = 0; k < GROUP_SIZE; k++) begin
      n = n + 3'(c[k]);
    end
    return n >= 3'(TRIP_VOTE_MIN);
  endfunction : vote_2oo4

  //////////////////////////////////////////////////////////////////////
  // Millisecond tick and input conditioning

  logic [TW-1:0] tick_cnt_q;
  logic tick_q;
  logic [N_IN-1:0] raw_in;
  logic [N_IN-1:0] sync1_q;
  logic [N_IN-1:0] sync2_q;
  logic [N_IN-1:0] hist_q;
  logic [N_IN-1:0] clean_q;
  logic [N_IN-1:0] prev_q;
  logic [N_GROUP-1:0] vote_prev_q;
  logic [CNT_W-1:0] init_cnt_q;
  logic init_done_q;
  logic init_prev_q;
  logic adopt;

  // Divider for the one-cycle millisecond enable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  assign raw_in = {sol_readback_in, sol_power_in, operate_pb_in,
                   bypass_pb_in, open_pb_in, close_pb_in,
                   protection_trip_in, group_close_in};

  // Two-stage synchroniser, then two matching samples a tick apart
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      hist_q <= '0;
      clean_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      if (tick_q) begin
        hist_q <= sync2_q;
        // Per bit, so one bouncing contact cannot stall the rest
        clean_q <= (sync2_q & hist_q) |
                   (clean_q & (sync2_q ^ hist_q));
      end
    end
  end

  // Hold off all action until inputs were sampled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      init_cnt_q <= '0;
      init_done_q <= 1'b0;
      init_prev_q <= 1'b0;
    end else begin
      init_prev_q <= init_done_q;
      if (tick_q && !init_done_q) begin
        init_cnt_q <= init_cnt_q + 1'b1;
        if (init_cnt_q == CNT_W'(INIT_SAMPLES - 1)) begin
          init_done_q <= 1'b1;
        end
      end
    end
  end

  assign adopt = init_done_q & ~init_prev_q;

  //////////////////////////////////////////////////////////////////////
  // Command decoding

  logic [N_GROUP-1:0] grp_lvl;
  logic [N_GROUP-1:0] vote;
  logic [N_VALVES-1:0] trip_op;
  logic [N_VALVES-1:0] close_lvl;
  logic [N_VALVES-1:0] close_init;
  logic [N_VALVES-1:0] open_edge;
  logic [N_VALVES-1:0] byp_edge;
  logic [N_VALVES-1:0] opr_edge;
  logic [N_VALVES-1:0] power_ok;
  logic any_close;

  // Edge history of cleaned contacts
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
      vote_prev_q <= '0;
    end else begin
      prev_q <= clean_q;
      vote_prev_q <= vote;
    end
  end

  assign grp_lvl = clean_q[IDX_GRP +: N_GROUP];
  assign trip_op = ~clean_q[IDX_TRIP +: N_VALVES];
  assign power_ok = clean_q[IDX_PWR +: N_VALVES];

  // Levels present and initiations, per valve
  always_comb begin
    int g;
    g = 0;
    for (int k = 0; k < N_GROUP; k++) begin
      vote[k] = vote_2oo4(trip_op[k*GROUP_SIZE +: GROUP_SIZE]);
    end
    for (int i = 0; i < N_VALVES; i++) begin
      g = i / GROUP_SIZE;
      close_lvl[i] = grp_lvl[g] | vote[g] | clean_q[IDX_CLOSE+i];
      close_init[i] = init_done_q & (
        (grp_lvl[g] & ~prev_q[IDX_GRP+g]) |
        (vote[g] & ~vote_prev_q[g]) |
        (clean_q[IDX_CLOSE+i] & ~prev_q[IDX_CLOSE+i]));
      open_edge[i] = init_done_q & clean_q[IDX_OPEN+i] &
                     ~prev_q[IDX_OPEN+i];
      byp_edge[i] = init_done_q & clean_q[IDX_BYP+i] & ~prev_q[IDX_BYP+i];
      opr_edge[i] = init_done_q & clean_q[IDX_OPR+i] & ~prev_q[IDX_OPR+i];
    end
  end

  assign any_close = |close_lvl;

  //////////////////////////////////////////////////////////////////////
  // Valve states; each instance is one side, nothing shared

  valve_state_t state_q [N_VALVES];
  logic [TMR_W-1:0] timer_q [N_VALVES];
  logic [N_VALVES-1:0] bypass_q;
  logic [N_VALVES-1:0] alarm_q;

  // State sequencing, frozen by bypass or a detected failure
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N_VALVES; i++) begin
        state_q[i] <= OPEN_STATE;
        timer_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_VALVES; i++) begin
        if (adopt) begin
          state_q[i] <= close_lvl[i] ? CLOSE_STATE :
            found_state(sol_t'(clean_q[IDX_RB+SOL_W*i +: SOL_W]));
          timer_q[i] <= TMR_W'(CLOSE_HOLD_TICKS);
        end else if (init_done_q && !bypass_q[i] && !alarm_q[i]) begin
          if (close_init[i]) begin
            state_q[i] <= CLOSE_STATE;
            timer_q[i] <= TMR_W'(CLOSE_HOLD_TICKS);
          end else begin
            unique case (state_q[i])
              CLOSE_STATE: begin
                if (timer_q[i] == '0) begin
                  state_q[i] <= KEEP_CLOSED_STATE;
                end else if (tick_q) begin
                  timer_q[i] <= timer_q[i] - 1'b1;
                end
              end
              KEEP_CLOSED_STATE: begin
                if (open_edge[i] && !close_lvl[i]) begin
                  state_q[i] <= OPEN_STATE;
                end
              end
              OPEN_STATE: begin
              end
            endcase
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Bypass and return to operate

  logic [N_VALVES-1:0] byp_pend_q;
  logic [N_VALVES-1:0] opr_pend_q;
  logic [N_VALVES-1:0] contact_q;

  // Entry waits out close; exit waits for the open contact
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bypass_q <= '0;
      byp_pend_q <= '0;
      opr_pend_q <= '0;
    end else begin
      for (int i = 0; i < N_VALVES; i++) begin
        if (bypass_q[i]) begin
          byp_pend_q[i] <= 1'b0;
          if (opr_edge[i]) begin
            opr_pend_q[i] <= 1'b1;
          end
          if (opr_pend_q[i] && !contact_q[i]) begin
            bypass_q[i] <= 1'b0;
            opr_pend_q[i] <= 1'b0;
          end
        end else begin
          opr_pend_q[i] <= 1'b0;
          if (byp_edge[i]) begin
            byp_pend_q[i] <= 1'b1;
          end
          if ((byp_pend_q[i] || byp_edge[i]) &&
              state_q[i] != CLOSE_STATE) begin
            bypass_q[i] <= 1'b1;
            byp_pend_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Manually initiated automatic test

  logic test_active_q;
  logic test_abort_q;
  logic [SEL_W-1:0] test_sel_q;
  logic [CNT_W-1:0] test_cnt_q;
  logic test_start;
  logic abort_clr;
  logic [N_VALVES-1:0] alarm_clr;

  assign test_start = reg_req.wr & (reg_req.addr == REG_CTRL) &
                      reg_req.wdata[CTRL_START_BIT];
  assign abort_clr = reg_req.wr & (reg_req.addr == REG_ALARM) &
                     reg_req.wdata[ALARM_ABORT_BIT];
  assign alarm_clr = (reg_req.wr && reg_req.addr == REG_ALARM) ?
                     reg_req.wdata[N_VALVES-1:0] : '0;

  // Test runs a fixed time, dropped at once by any close
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      test_active_q <= 1'b0;
      test_abort_q <= 1'b0;
      test_sel_q <= '0;
      test_cnt_q <= '0;
    end else begin
      if (abort_clr) begin
        test_abort_q <= 1'b0;
      end
      if (test_active_q) begin
        if (any_close) begin
          test_active_q <= 1'b0;
          test_abort_q <= 1'b1;
        end else if (tick_q && test_cnt_q == '0) begin
          test_active_q <= 1'b0;
        end else if (tick_q) begin
          test_cnt_q <= test_cnt_q - 1'b1;
        end
      end else if (test_start && !any_close && init_done_q) begin
        test_active_q <= 1'b1;
        test_cnt_q <= CNT_W'(TEST_MS);
        test_sel_q <= reg_req.wdata[CTRL_SEL_LSB +: SEL_W];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs and read-back checking

  logic [SET_W-1:0] settle_q [N_VALVES];
  logic [N_VALVES-1:0] mismatch;

  // Solenoids, status, test contacts and lamps
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      side_sol <= {N_VALVES{SOL_OPEN}};
      status_out <= '0;
      contact_q <= '0;
    end else begin
      for (int i = 0; i < N_VALVES; i++) begin
        if (init_done_q && !bypass_q[i]) begin
          side_sol[i] <= pattern(state_q[i]);
        end
        status_out[i] <= power_ok[i] & ~test_active_q &
                         ~bypass_q[i];
        contact_q[i] <= (bypass_q[i] & ~opr_pend_q[i]) |
          (test_active_q & (test_sel_q == SEL_W'(i)));
      end
    end
  end

  assign test_enable_out = contact_q;
  assign bypass_lamp = bypass_q;
  assign discrepancy_alarm = alarm_q;

  // Settling time after each output change
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N_VALVES; i++) begin
        settle_q[i] <= SET_W'(SETTLE_MS);
      end
    end else begin
      for (int i = 0; i < N_VALVES; i++) begin
        if (side_sol[i] != pattern(state_q[i]) && !bypass_q[i]) begin
          settle_q[i] <= SET_W'(SETTLE_MS);
        end else if (tick_q && settle_q[i] != '0) begin
          settle_q[i] <= settle_q[i] - 1'b1;
        end
      end
    end
  end

  // Continuous compare of read-back with driven pattern
  always_comb begin
    for (int i = 0; i < N_VALVES; i++) begin
      mismatch[i] = init_done_q & (settle_q[i] == '0) &
        (sol_t'(clean_q[IDX_RB+SOL_W*i +: SOL_W]) != side_sol[i]);
    end
  end

  // Sticky alarm; a new mismatch beats the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= mismatch | (alarm_q & ~alarm_clr);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register read port

  logic [DATA_W-1:0] state_word;
  logic [DATA_W-1:0] alarm_word;
  logic [DATA_W-1:0] ctrl_word;

  // Read words
  always_comb begin
    state_word = '0;
    alarm_word = '0;
    ctrl_word = '0;
    for (int i = 0; i < N_VALVES; i++) begin
      state_word[2*i +: 2] = state_q[i];
      state_word[STATE_BYP_LSB+i] = bypass_q[i];
    end
    alarm_word[N_VALVES-1:0] = alarm_q;
    alarm_word[ALARM_ABORT_BIT] = test_abort_q;
    alarm_word[ALARM_INIT_BIT] = init_done_q;
    ctrl_word[CTRL_ACTIVE_BIT] = test_active_q;
    ctrl_word[CTRL_SEL_LSB +: SEL_W] = test_sel_q;
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        REG_CTRL: reg_rdata <= ctrl_word;
        REG_STATE: reg_rdata <= state_word;
        REG_ALARM: reg_rdata <= alarm_word;
        REG_IN0: reg_rdata <= clean_q[DATA_W-1:0];
        REG_IN1: reg_rdata <= clean_q[2*DATA_W-1:DATA_W];
        REG_IN2: reg_rdata <= DATA_W'(clean_q[N_IN-1:2*DATA_W]);
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks per valve, then for the whole side

  for (genvar gi = 0; gi < N_VALVES; gi++) begin : g_chk
    sequence s_enter;
      $rose(bypass_q[gi]);
    endsequence
    sequence s_latched;
      contact_q[gi] && !status_out[gi] && bypass_lamp[gi];
    endsequence
    sol_pattern_a: assert property (
      init_done_q && !bypass_q[gi] |=>
        side_sol[gi] == pattern($past(state_q[gi])))
      else $error("solenoid pattern differs from state");
    close_cmd_a: assert property (
      close_init[gi] && !bypass_q[gi] && !alarm_q[gi] |=>
        state_q[gi] == CLOSE_STATE &&
        timer_q[gi] == TMR_W'(CLOSE_HOLD_TICKS))
      else $error("close command not taken");
    keep_delay_a: assert property (
      state_q[gi] == KEEP_CLOSED_STATE &&
        $past(state_q[gi]) == CLOSE_STATE |->
        $past(timer_q[gi]) == '0)
      else $error("keep-closed before delay expired");
    open_block_a: assert property (
      close_lvl[gi] && state_q[gi] != OPEN_STATE |=>
        state_q[gi] != OPEN_STATE)
      else $error("open taken during close command");
    bypass_hold_a: assert property (
      bypass_q[gi] |=> $stable(side_sol[gi]) && $stable(state_q[gi]))
      else $error("outputs moved in bypass");
    bypass_wait_a: assert property (
      $rose(bypass_q[gi]) |-> $past(state_q[gi]) != CLOSE_STATE)
      else $error("bypass entered during close");
    enter_order_a: assert property (
      s_enter |-> !contact_q[gi] ##1 s_latched)
      else $error("bypass entry out of order");
    exit_order_a: assert property (
      $fell(bypass_q[gi]) |-> !$past(contact_q[gi]))
      else $error("bypass left with contact closed");
    contact_idle_a: assert property (
      !bypass_q[gi] && !test_active_q |=> !contact_q[gi])
      else $error("test contact closed in normal run");
    alarm_set_a: assert property (
      mismatch[gi] |=> alarm_q[gi] && discrepancy_alarm[gi])
      else $error("mismatch not alarmed");
    fail_hold_a: assert property (
      alarm_q[gi] |=> $stable(state_q[gi]))
      else $error("state changed after failure");
  end

  status_test_a: assert property (
    test_active_q |=> status_out == '0)
    else $error("status held during test");
  test_yield_a: assert property (
    test_active_q && any_close |=> !test_active_q && test_abort_q)
    else $error("test kept running under actuation");

endmodule : valve_actuation_logic

// *** src/valve_actuation_pkg.sv ***
// Constants and types for the isolation valve actuation logic
// How it works
// - One status output per train per valve
// - Status needs solenoid power and no test
// - Read back solenoids, alarm any mismatch
// - One instance serves one side only
// - Close, keep-closed, open solenoid patterns
// - Open is the normal operating state
// - On detected failure hold current state
// - Group close closes all four valves
// - Close held 60 s, then keep-closed
// - Two-of-four trip vote closes group
// - Single close closes only that valve
// - Single open opens only that valve
// - Open ignored while any close for that valve present
// - Open ignored until close delay expires
// - Bypass blocks every command to that valve on train
// - One test-enable output per train per valve
// - Test contact open except during test or bypass
// - Self-test yields to any actuation input
// - Manual, initiated and continuous checks
// - Trip and solenoid power contacts normally closed, others open
// - Pushbutton pulses latched into state
// - Bypass waits for close timer to finish
// - Bypass latches outputs before contact closes
package valve_actuation_pkg;
  localparam int N_VALVES = 8;
  localparam int N_GROUP = 2;
  localparam int GROUP_SIZE = 4;
  localparam int TRIP_VOTE_MIN = 2;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int CLOSE_HOLD_MS = 60000;
  localparam int SETTLE_MS = 50;
  localparam int TEST_MS = 100;
  localparam int INIT_SAMPLES = 3;
  localparam int TMR_W = 16;
  localparam int SET_W = 8;
  localparam int CNT_W = 8;
  // Positions in the packed raw input vector
  localparam int IDX_GRP = 0;
  localparam int IDX_TRIP = 2;
  localparam int IDX_CLOSE = 10;
  localparam int IDX_OPEN = 18;
  localparam int IDX_BYP = 26;
  localparam int IDX_OPR = 34;
  localparam int IDX_PWR = 42;
  localparam int IDX_RB = 50;
  localparam int SOL_W = 3;
  localparam int N_IN = 74;
  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ALARM = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IN0 = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IN1 = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IN2 = 8'h14;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ACTIVE_BIT = 1;
  localparam int CTRL_SEL_LSB = 4;
  localparam int SEL_W = 3;
  localparam int STATE_BYP_LSB = 16;
  localparam int ALARM_ABORT_BIT = 8;
  localparam int ALARM_INIT_BIT = 9;
  // Solenoid set of one valve side
  typedef struct packed {
    logic operate_1;
    logic operate_2;
    logic hold;
  } sol_t;
  localparam sol_t SOL_CLOSE = 3'h0;
  localparam sol_t SOL_KEEP = 3'h1;
  localparam sol_t SOL_OPEN = 3'h6;
  typedef enum logic [1:0] {
    CLOSE_STATE,
    KEEP_CLOSED_STATE,
    OPEN_STATE
  } valve_state_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : valve_actuation_pkg
